//--- design/spimsp_top.sv
// serial master/slave port with apb register access
// assumes pins sampled synchronously to pclk; pad logic resolves the enables
`timescale 1ns/1ns
// How it works
// - port pins claimed over segment and gpio
// - edge select 0: change rising, sample falling
// - edge select 1: change falling, sample rising
// - control bit 6 enables the port
// - slave: unread byte plus new sets overflow
// - shift enable starts byte, self clears
// - control bit 3 sets data-out rest level
// - baud field divides clock or uses timer
// - codes 110/111 slave, select honoured or ignored
// - interrupt reaches output only when masked in
// - status bit 7 picks bit order
// - status bits 6..5 set release delay
// - status bit 3 makes data-out open drain
// - status bit 2 makes clock open drain
// - buffer full flag shows received byte
// - completion copies shifter and sets full together
// - shifting waits for clock edge with enable
// - reading receive buffer clears full flag
// - transmit buffer ignores writes while shifting
// - select high with code 110: data-out released, pins ignored
module spimsp_top #(
  parameter int ADDR_W = 12,
  parameter int BAUD_CNT_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic ss_n_i,
  input wire logic t2_tick_i,
  output logic irq_o,
  output logic [3:0] pin_claim_o
);

  if (ADDR_W < 12) begin : g_bad_addr
    $error("spimsp_top needs ADDR_W of at least 12");
  end

  typedef struct packed {
    spimsp_pkg::spimsp_state_t st;
    logic [7:0] status;
    logic [7:0] control;
    logic [7:0] rx_buf;
    logic [7:0] tx_buf;
    logic [7:0] imask;
    logic [7:0] istat;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic [4:0] dly;
    logic sck_prev;
    logic sck;
    logic so;
    logic so_oe;
    logic sck_oe;
    logic irq;
    logic [3:0] claim;
    logic [7:0] rdata;
    logic ready;
    logic slverr;
  } spimsp_top_state_t;

  spimsp_top_state_t q;
  spimsp_top_state_t d;
  logic half_tick;
  logic baud_run;

  // map a byte address onto a register select code
  function automatic spimsp_pkg::spimsp_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    logic [11:0] a12;
    a12 = a[11:0];
    // upper address bits must be zero; also legal when ADDR_W is exactly 12
    if (a != ADDR_W'(a12)) begin
      return spimsp_pkg::SEL_NONE;
    end
    case (a12)
      spimsp_pkg::ADDR_STATUS: return spimsp_pkg::SEL_STATUS;
      spimsp_pkg::ADDR_CONTROL: return spimsp_pkg::SEL_CONTROL;
      spimsp_pkg::ADDR_RXBUF: return spimsp_pkg::SEL_RXBUF;
      spimsp_pkg::ADDR_TXBUF: return spimsp_pkg::SEL_TXBUF;
      spimsp_pkg::ADDR_IMASK: return spimsp_pkg::SEL_IMASK;
      spimsp_pkg::ADDR_ISTAT: return spimsp_pkg::SEL_ISTAT;
      default: return spimsp_pkg::SEL_NONE;
    endcase
  endfunction

  // master clock divider runs only while a byte is in flight
  assign baud_run = (q.st == spimsp_pkg::ST_SHIFT) && q.control[spimsp_pkg::CTL_EN]
                    && !(q.control[spimsp_pkg::CTL_BAUD_HI]
                    && q.control[spimsp_pkg::CTL_BAUD_HI - 1]);

  spimsp_baud #(
    .CNT_W(BAUD_CNT_W)
  ) u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(baud_run),
    .code(q.control[spimsp_pkg::CTL_BAUD_HI:spimsp_pkg::CTL_BAUD_LO]),
    .t2_tick(t2_tick_i),
    .half_tick(half_tick)
  );

  // next-state logic: bus access first, then the shifter, then disable
  always_comb begin
    logic en;
    logic clock_edge_select;
    logic slave;
    logic ss_ok;
    logic edge_hit;
    logic lvl;
    logic lsb_first;
    logic setup;
    logic done;
    logic [2:0] code;
    logic [7:0] wd;
    logic [7:0] nxt;
    spimsp_pkg::spimsp_sel_t sel;
    en = 1'b0;
    clock_edge_select = 1'b0;
    slave = 1'b0;
    ss_ok = 1'b0;
    edge_hit = 1'b0;
    lvl = 1'b0;
    lsb_first = 1'b0;
    code = 3'h0;
    nxt = 8'h00;
    d = q;
    wd = pwdata[7:0];
    sel = reg_sel(paddr);
    setup = psel && !penable;
    done = psel && penable && q.ready;

    // apb answer: registered one cycle after setup
    d.ready = setup;
    d.slverr = setup && (sel == spimsp_pkg::SEL_NONE);
    d.rdata = 8'h00;
    if (setup && !pwrite) begin
      case (sel)
        spimsp_pkg::SEL_STATUS: d.rdata = q.status;
        spimsp_pkg::SEL_CONTROL: d.rdata = q.control;
        spimsp_pkg::SEL_RXBUF: d.rdata = q.rx_buf;
        spimsp_pkg::SEL_TXBUF: d.rdata = q.tx_buf;
        spimsp_pkg::SEL_IMASK: d.rdata = q.imask;
        spimsp_pkg::SEL_ISTAT: d.rdata = q.istat;
        default: d.rdata = 8'h00;
      endcase
    end

    // register writes and read side effects at the access edge
    if (done && !pwrite && sel == spimsp_pkg::SEL_RXBUF) begin
      d.status[spimsp_pkg::STS_FULL] = 1'b0;
    end
    if (done && pwrite) begin
      case (sel)
        spimsp_pkg::SEL_STATUS: begin
          d.status = (wd & spimsp_pkg::STATUS_WMASK) | (q.status & ~spimsp_pkg::STATUS_WMASK);
        end
        spimsp_pkg::SEL_CONTROL: begin
          d.control[spimsp_pkg::CTL_CES] = wd[spimsp_pkg::CTL_CES];
          d.control[spimsp_pkg::CTL_EN] = wd[spimsp_pkg::CTL_EN];
          d.control[spimsp_pkg::CTL_OVF] = wd[spimsp_pkg::CTL_OVF];
          d.control[spimsp_pkg::CTL_IDLE] = wd[spimsp_pkg::CTL_IDLE];
          d.control[spimsp_pkg::CTL_BAUD_HI:spimsp_pkg::CTL_BAUD_LO] = wd[2:0];
          if (wd[spimsp_pkg::CTL_SSE] && wd[spimsp_pkg::CTL_EN]
              && q.st != spimsp_pkg::ST_SHIFT) begin
            d.control[spimsp_pkg::CTL_SSE] = 1'b1;
            d.shreg = q.tx_buf;
            d.bitcnt = 4'h0;
            d.st = spimsp_pkg::ST_SHIFT;
          end
        end
        spimsp_pkg::SEL_RXBUF: d.rx_buf = wd;
        spimsp_pkg::SEL_TXBUF: begin
          if (!q.control[spimsp_pkg::CTL_SSE]) begin
            d.tx_buf = wd;
          end
        end
        spimsp_pkg::SEL_IMASK: d.imask = wd;
        spimsp_pkg::SEL_ISTAT: d.istat = wd;
        default: d.istat = d.istat;
      endcase
    end

    // mode decode from the settings now in force
    en = q.control[spimsp_pkg::CTL_EN];
    clock_edge_select = q.control[spimsp_pkg::CTL_CES];
    code = q.control[spimsp_pkg::CTL_BAUD_HI:spimsp_pkg::CTL_BAUD_LO];
    slave = code[2] && code[1];
    ss_ok = (code != spimsp_pkg::BAUD_SLV_SS) || !ss_n_i;
    lsb_first = q.status[spimsp_pkg::STS_ORDER];
    d.sck_prev = sck_i;

    // clock edges: own divider in master, pin edges in slave
    if (q.st == spimsp_pkg::ST_SHIFT && en) begin
      if (!slave) begin
        edge_hit = half_tick;
        lvl = ~q.sck;
        if (half_tick) begin
          d.sck = lvl;
        end
      end else begin
        edge_hit = ss_ok && (sck_i != q.sck_prev);
        lvl = sck_i;
      end
    end else if (!slave) begin
      d.sck = clock_edge_select; // master clock rests at the edge-select level
    end

    // shift: change edge drives the next bit, sample edge takes one in
    if (edge_hit) begin
      if (lvl != clock_edge_select) begin
        d.so = lsb_first ? q.shreg[0] : q.shreg[7];
      end else begin
        nxt = lsb_first ? {si_i, q.shreg[7:1]} : {q.shreg[6:0], si_i};
        d.shreg = nxt;
        d.bitcnt = q.bitcnt + 4'h1;
        if (q.bitcnt == spimsp_pkg::LAST_BIT) begin
          d.control[spimsp_pkg::CTL_SSE] = 1'b0;
          d.istat[spimsp_pkg::IRQ_BIT] = 1'b1;
          if (slave && d.status[spimsp_pkg::STS_FULL]) begin
            d.control[spimsp_pkg::CTL_OVF] = 1'b1;
          end else begin
            d.rx_buf = nxt;
            d.status[spimsp_pkg::STS_FULL] = 1'b1;
          end
          d.st = spimsp_pkg::ST_TAIL;
          d.dly = 5'(({3'h0, q.status[spimsp_pkg::STS_DLY_HI:spimsp_pkg::STS_DLY_LO]} + 5'h1)
                  * spimsp_pkg::DLY_UNIT_CYC - 1);
        end
      end
    end

    // hold the last bit, then release data-out to its rest level
    if (q.st == spimsp_pkg::ST_TAIL && d.st == spimsp_pkg::ST_TAIL) begin
      if (q.dly == 5'h00) begin
        d.so = ~q.control[spimsp_pkg::CTL_IDLE];
        d.st = spimsp_pkg::ST_IDLE;
      end else begin
        d.dly = q.dly - 5'h01;
      end
    end else if (q.st == spimsp_pkg::ST_IDLE && d.st == spimsp_pkg::ST_IDLE) begin
      d.so = ~q.control[spimsp_pkg::CTL_IDLE];
    end

    // a disabled port drops any byte in flight
    if (!d.control[spimsp_pkg::CTL_EN]) begin
      d.st = spimsp_pkg::ST_IDLE;
      d.control[spimsp_pkg::CTL_SSE] = 1'b0;
    end

    // registered pad controls and interrupt from the next state
    en = d.control[spimsp_pkg::CTL_EN];
    code = d.control[spimsp_pkg::CTL_BAUD_HI:spimsp_pkg::CTL_BAUD_LO];
    slave = code[2] && code[1];
    ss_ok = (code != spimsp_pkg::BAUD_SLV_SS) || !ss_n_i;
    d.so_oe = en && ss_ok && (!d.status[spimsp_pkg::STS_OD_SO] || !d.so);
    d.sck_oe = en && !slave && (!d.status[spimsp_pkg::STS_OD_SCK] || !d.sck);
    d.irq = d.istat[spimsp_pkg::IRQ_BIT] && d.imask[spimsp_pkg::IRQ_BIT];
    d.claim = {en && (code == spimsp_pkg::BAUD_SLV_SS), en, en, en};
  end

  // state register; all writable bits clear, data-out rests high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.st <= spimsp_pkg::ST_IDLE;
      q.status <= spimsp_pkg::STATUS_RST;
      q.control <= spimsp_pkg::CONTROL_RST;
      q.rx_buf <= spimsp_pkg::BUF_RST;
      q.tx_buf <= spimsp_pkg::BUF_RST;
      q.imask <= spimsp_pkg::IMASK_RST;
      q.istat <= spimsp_pkg::ISTAT_RST;
      q.shreg <= 8'h00;
      q.bitcnt <= 4'h0;
      q.dly <= 5'h00;
      q.sck_prev <= 1'b0;
      q.sck <= 1'b0;
      q.so <= 1'b1;
      q.so_oe <= 1'b0;
      q.sck_oe <= 1'b0;
      q.irq <= 1'b0;
      q.claim <= 4'h0;
      q.rdata <= 8'h00;
      q.ready <= 1'b0;
      q.slverr <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign prdata = {24'h0000_00, q.rdata};
  assign pready = q.ready;
  assign pslverr = q.slverr;
  assign so_o = q.so;
  assign so_oe = q.so_oe;
  assign sck_o = q.sck;
  assign sck_oe = q.sck_oe;
  assign irq_o = q.irq;
  assign pin_claim_o = q.claim;

endmodule // spimsp_top

//--- pkg/spimsp_pkg.sv
// constants, field positions and types for the serial master/slave port
// assumes a 32-bit apb slave with byte addresses; 8-bit registers in the low lane
package spimsp_pkg;

  // register indices as printed, byte address is base plus four times the index
  localparam logic [11:0] IDX_STATUS = 12'h000c;
  localparam logic [11:0] IDX_CONTROL = 12'h000d;
  localparam logic [11:0] IDX_RXBUF = 12'h000e;
  localparam logic [11:0] IDX_TXBUF = 12'h000f;
  localparam logic [11:0] IDX_IMASK = 12'h000e;
  localparam logic [11:0] IDX_ISTAT = 12'h000f;
  // the two register banks sit at separate bases
  localparam logic [11:0] BANK2_BASE = 12'h0000;
  localparam logic [11:0] BANK0_BASE = 12'h0100;
  localparam logic [11:0] ADDR_STATUS = BANK2_BASE + (IDX_STATUS << 2);
  localparam logic [11:0] ADDR_CONTROL = BANK2_BASE + (IDX_CONTROL << 2);
  localparam logic [11:0] ADDR_RXBUF = BANK2_BASE + (IDX_RXBUF << 2);
  localparam logic [11:0] ADDR_TXBUF = BANK2_BASE + (IDX_TXBUF << 2);
  localparam logic [11:0] ADDR_IMASK = BANK0_BASE + (IDX_IMASK << 2);
  localparam logic [11:0] ADDR_ISTAT = BANK0_BASE + (IDX_ISTAT << 2);

  // serial_status fields
  localparam int STS_ORDER = 7;
  localparam int STS_DLY_HI = 6;
  localparam int STS_DLY_LO = 5;
  localparam int STS_OD_SO = 3;
  localparam int STS_OD_SCK = 2;
  localparam int STS_FULL = 0;
  localparam logic [7:0] STATUS_WMASK = 8'hec;

  // serial_control fields
  localparam int CTL_CES = 7;
  localparam int CTL_EN = 6;
  localparam int CTL_OVF = 5;
  localparam int CTL_SSE = 4;
  localparam int CTL_IDLE = 3;
  localparam int CTL_BAUD_HI = 2;
  localparam int CTL_BAUD_LO = 0;

  // interrupt mask and status bit of this port
  localparam int IRQ_BIT = 4;

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [7:0] IMASK_RST = 8'h00;
  localparam logic [7:0] ISTAT_RST = 8'h00;

  // baud select codes
  localparam logic [2:0] BAUD_TIMER2 = 3'h5;
  localparam logic [2:0] BAUD_SLV_SS = 3'h6;
  localparam logic [2:0] BAUD_SLV_FREE = 3'h7;

  // data-out release delay step, in clock periods
  localparam int DLY_UNIT_CLK = 8;
  localparam int DLY_UNIT_CYC = DLY_UNIT_CLK;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // register select codes
  typedef enum logic [2:0] {
    SEL_STATUS = 3'h0,
    SEL_CONTROL = 3'h1,
    SEL_RXBUF = 3'h2,
    SEL_TXBUF = 3'h3,
    SEL_IMASK = 3'h4,
    SEL_ISTAT = 3'h5,
    SEL_NONE = 3'h7
  } spimsp_sel_t;

  // transfer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_TAIL = 3'b100
  } spimsp_state_t;

endpackage

//--- design/spimsp_baud.sv
// half-period tick generator for the master serial clock
// assumes run is held for the whole byte; the timer tick is a one-cycle pulse
`timescale 1ns/1ns
module spimsp_baud #(
  parameter int CNT_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] code,
  input wire logic t2_tick,
  output logic half_tick
);

  if (CNT_W < 5) begin : g_bad_width
    $error("spimsp_baud needs CNT_W of at least 5");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } spimsp_baud_state_t;

  spimsp_baud_state_t q;
  spimsp_baud_state_t d;
  logic [CNT_W-1:0] tc;

  // codes 0 to 4: half period is 2^code cycles, so the clock is the oscillator over 2^(code+1); code 5: one timer tick
  always_comb begin
    d = q;
    tc = (CNT_W'(1) << code) - CNT_W'(1);
    d.tick = 1'b0;
    if (!run) begin
      d.cnt = '0;
    end else if (code == spimsp_pkg::BAUD_TIMER2) begin
      d.cnt = '0;
      d.tick = t2_tick;
    end else if (q.cnt >= tc) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign half_tick = q.tick;

endmodule // spimsp_baud

//--- test/spimsp_chk.sv
// port checker for the serial master/slave port
// assumes binding onto spimsp_top; mirrors the software-written bits
`timescale 1ns/1ns
module spimsp_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic ss_n_i,
  input wire logic irq_o,
  input wire logic [3:0] pin_claim_o
);
  logic [7:0] st_q, ct_q, im_q;
  logic w;
  assign w = psel & penable & pready & pwrite;
  // shadow of written status, control and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= 8'h00;
      ct_q <= 8'h00;
      im_q <= 8'h00;
    end else if (w) begin
      if (paddr == spimsp_pkg::ADDR_STATUS) st_q <= pwdata[7:0];
      if (paddr == spimsp_pkg::ADDR_CONTROL) ct_q <= pwdata[7:0];
      if (paddr == spimsp_pkg::ADDR_IMASK) im_q <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_ERR_EMPTY: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("bad error response");
  AST_SO_OPEN_DRAIN: assert property (st_q[3] && $past(st_q[3]) && so_oe |-> !so_o)
    else $error("data out drives high");
  AST_SCK_OPEN_DRAIN: assert property (st_q[2] && $past(st_q[2]) && sck_oe |-> !sck_o)
    else $error("clock drives high");
  AST_IRQ_MASKED: assert property (!im_q[4] && !$past(im_q[4]) |-> !irq_o)
    else $error("interrupt while masked");
  AST_OFF_NO_CLAIM: assert property (!ct_q[6] ##1 !ct_q[6] |-> pin_claim_o == 4'h0)
    else $error("pins claimed while off");
  AST_REST_LEVEL: assert property (!ct_q[6] ##1 !ct_q[6] && $stable(ct_q[3]) |-> so_o == !ct_q[3])
    else $error("wrong rest level");
  AST_SS_RELEASE: assert property ((ct_q[2:0] == 3'h6 && ss_n_i) [*3] |-> !so_oe)
    else $error("data out driven while deselected");
  AST_SLAVE_NO_SCK: assert property ($past(ct_q[2:1]) == 2'b11 && ct_q[2:1] == 2'b11 |-> !sck_oe)
    else $error("slave drives clock");
  cover property (w && paddr == spimsp_pkg::ADDR_CONTROL && pwdata[4]);
  cover property (pslverr);
  cover property (irq_o);
endmodule // spimsp_chk
bind spimsp_top spimsp_chk spimsp_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .so_o, .so_oe, .sck_o, .sck_oe, .ss_n_i,
  .irq_o, .pin_claim_o);

//--- test/spimsp_peer.sv
// far-side slave device on the master serial clock
// assumes load pulses before each frame; clock idles between frames
`timescale 1ns/1ns
module spimsp_peer (
  input wire logic load,
  input wire logic sck,
  input wire logic so,
  input wire logic clock_edge_select,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output logic si,
  output logic [7:0] rx
);
  int n = 0;
  int m = 0;
  initial si = 1'b0;
  // new frame clears counters
  always @(posedge load) begin
    n = 0;
    m = 0;
    rx = 8'h00;
  end
  // change level presents a bit, sample level captures one
  always @(sck) begin
    if (!load && sck !== clock_edge_select && n < 8) begin
      si = lsb ? tx[n] : tx[7-n];
      n++;
    end else if (!load && sck === clock_edge_select && m < n) begin
      rx = lsb ? {so, rx[7:1]} : {rx[6:0], so};
      m++;
      if (m == 8) si = ~si; // released line stops showing data
    end
  end
endmodule // spimsp_peer

//--- test/tb.sv
// bench for the serial port: apb tasks, master and slave byte scenarios
// assumes spimsp_top with its bound checker and the peer model
`timescale 1ns/1ns
module tb;
  localparam logic [11:0] A_ST = spimsp_pkg::ADDR_STATUS;
  localparam logic [11:0] A_CT = spimsp_pkg::ADDR_CONTROL;
  localparam logic [11:0] A_RX = spimsp_pkg::ADDR_RXBUF;
  localparam logic [11:0] A_TX = spimsp_pkg::ADDR_TXBUF;
  localparam logic [11:0] A_IM = spimsp_pkg::ADDR_IMASK;
  localparam logic [11:0] A_IS = spimsp_pkg::ADDR_ISTAT;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sck_d = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
  logic pready, pslverr, so_o, so_oe, sck_o, sck_oe, irq_o, psi, si_i, so_w, sck_w, rerr;
  logic sck_i = 0, ss_n_i = 1, t2_tick_i = 0, si_tb = 0, slv = 0, load = 1;
  logic ces_m = 0, lsb_m = 0;
  logic [7:0] tx_m = 8'h00, prx;
  logic [3:0] pin_claim_o;
  int n_errors = 0, n_compared = 0, cyc = 0, ntog = 0;
  int tog [16];
  spimsp_top #(.ADDR_W(12), .BAUD_CNT_W(5)) spimsp_top_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .si_i, .so_o, .so_oe,
    .sck_i, .sck_o, .sck_oe, .ss_n_i, .t2_tick_i, .irq_o, .pin_claim_o);
  spimsp_peer spimsp_peer_inst (.load, .sck(sck_w), .so(so_w), .clock_edge_select(ces_m), .lsb(lsb_m),
    .tx(tx_m), .si(psi), .rx(prx));
  // wires with pull-ups, data in from peer or bench
  assign so_w = so_oe ? so_o : 1'b1;
  assign sck_w = sck_oe ? sck_o : 1'b1;
  assign si_i = slv ? si_tb : psi;
  // clock, cycle count, timer tick, timeout
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    t2_tick_i <= (cyc % 4 == 0);
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  // log of master clock toggles
  always @(posedge pclk) begin
    if (sck_o !== sck_d && ntog < 16) tog[ntog] = cyc;
    if (sck_o !== sck_d) ntog++;
    sck_d = sck_o;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    chk(rv & (w ? 32'hffff_ffff : 32'hffff_ff00), 32'h0000_0000);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1, a, {24'h00_0000, d});
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(0, a, 0);
    chk(rerr, 0);
    chk(rv & {24'hff_ffff, m}, {24'h00_0000, e});
  endtask
  task automatic t_regs();
    rc(A_ST, 8'hff, 8'h00);
    rc(A_CT, 8'hff, 8'h00);
    rc(A_IM, 8'hff, 8'h00);
    rc(A_IS, 8'hff, 8'h00);
    wr(A_ST, 8'hff);
    rc(A_ST, 8'hff, 8'hec);
    wr(A_ST, 8'h00);
    apb(0, 12'h004, 0);
    chk(rerr, 1);
    chk(rv, 0);
    $display("regs done");
  endtask
  task automatic t_master(input logic c, l, input logic [2:0] b, input logic [1:0] td,
      input logic [7:0] tx);
    logic lb;
    int k;
    lb = l ? tx[7] : tx[0];
    ces_m = c;
    lsb_m = l;
    tx_m = ~tx;
    load = 1;
    wr(A_ST, {l, td, 1'b0, c, c, 2'b00});
    wr(A_TX, tx);
    wr(A_CT, {c, 2'b10, 1'b0, lb, b});
    // peer stays parked while the clock pin settles to its new rest level
    repeat (4) @(posedge pclk);
    load = 0;
    ntog = 0;
    wr(A_CT, {c, 2'b10, 1'b1, lb, b});
    rc(A_CT, 8'h10, 8'h10);
    wr(A_TX, 8'h00);
    k = 0;
    do begin
      apb(0, A_CT, 0);
      k++;
    end while (rv[4] !== 1'b0 && k < 200);
    chk(rv[4], 0);
    k = 0;
    while (so_o === lb && k < 100) begin
      @(posedge pclk);
      k++;
    end
    chk(cyc - tog[15], 8 * (td + 1));
    chk(tog[1] - tog[0], b < 5 ? 1 << b : 4);
    chk(ntog, 16);
    chk(prx, tx);
    rc(A_ST, 8'h01, 8'h01);
    rc(A_IS, 8'h10, 8'h10);
    chk(irq_o, 1);
    rc(A_RX, 8'hff, ~tx);
    rc(A_TX, 8'hff, tx);
    rc(A_ST, 8'h01, 8'h00);
    wr(A_IS, 8'h00);
    repeat (2) @(posedge pclk);
    chk(irq_o, 0);
    $display("master code %0d done", b);
  endtask
  task automatic sbyte(input logic [7:0] d, input logic s, output logic [7:0] q);
    @(posedge pclk);
    ss_n_i <= s;
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge pclk);
      si_tb <= d[i];
      sck_i <= 1;
      repeat (4) @(posedge pclk);
      sck_i <= 0;
      q[i] = so_w;
    end
    repeat (4) @(posedge pclk);
    ss_n_i <= 1;
    si_tb <= ~d[0];
  endtask
  task automatic t_slave();
    logic [7:0] q;
    slv <= 1;
    wr(A_ST, 8'h00);
    wr(A_TX, 8'hc3);
    wr(A_CT, 8'h56);
    sbyte(8'h3c, 1'b1, q);
    chk(q, 8'hff);
    rc(A_ST, 8'h01, 8'h00);
    sbyte(8'ha5, 1'b0, q);
    chk(q, 8'hc3);
    rc(A_ST, 8'h01, 8'h01);
    wr(A_TX, 8'h0f);
    wr(A_CT, 8'h57);
    sbyte(8'h99, 1'b1, q);
    chk(q, 8'h0f);
    rc(A_CT, 8'h20, 8'h20);
    rc(A_RX, 8'hff, 8'ha5);
    slv <= 0;
    $display("slave done");
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_regs();
    wr(A_IM, 8'h10);
    t_master(0, 0, 3'h0, 2'h0, 8'h96);
    t_master(1, 1, 3'h1, 2'h3, 8'h4b);
    t_master(0, 0, 3'h2, 2'h2, 8'h3b);
    t_master(1, 0, 3'h3, 2'h0, 8'h5a);
    t_master(0, 1, 3'h4, 2'h1, 8'hd2);
    t_master(1, 0, 3'h5, 2'h2, 8'h6d);
    t_slave();
    final_report();
  end
endmodule // tb
